/* adcsq_top.sv */
// Summary of operation
// R01: Result read beats completion; store afterwards
// R02: Control write at completion drops result, interrupt
// R03: Channel rewrite leaves done flag alone
// R04: Software clears flag before resuming conversions
// R05: Early start: discard first result
// R06: Control writes may spoil result registers
// R07: Software reads result before control writes
// R08: Software clears run, enable before deep stop
// R09: Run off, enable on: comparator only
// R10: Conversion time includes sampling time
// R11: No alternate pin function while converting
// R12: No shared port access while converting
// R13: Run bit starts repeated back-to-back conversions
// R14: Each result stored wide, narrow; raises interrupt
// R15: Control write aborts, restarts when running
// R16: Clearing run stops at once, result undefined
// R17: Done flag set by completion, cleared by write
//
// The plain strobed port and the register offsets were chosen for this implementation.
`include "adcsq_params.svh"
module adcsq_top import adcsq_pkg::*; (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [2:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        cmp_hi_i,
    output logic             comp_pwr_o,
    output logic      [1:0]  chan_o,
    output logic             sample_o,
    output logic      [9:0]  trial_o,
    output logic             busy_o,
    output logic             irq_o
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic        cmp_s1_q, cmp_s2_q;      // Comparator synchroniser
    logic [7:0]  mode_q,   mode_d;        // Converter mode register
    logic [1:0]  chan_q,   chan_d;        // Channel select register
    logic [9:0]  wide_q,   wide_d;        // Result register
    logic        pend_q,   pend_d;        // Result held back by a read
    logic [9:0]  pval_q,   pval_d;        // Held-back result
    logic        flag_q,   flag_d;        // Conversion done flag
    logic        stat_q,   stat_d;        // Sticky interrupt status
    logic        mask_q,   mask_d;        // Interrupt mask
    logic [15:0] rdata_q,  rdata_d;       // Read data
    logic        irq_q,    irq_d;         // Interrupt line
    logic        wr_ctl;                  // Write to mode or channel
    logic        rd_res;                  // Read of a result register
    logic        ev;                      // Accepted completion
    logic        done;                    // Completion from sequencer
    logic [9:0]  res;                     // Result from sequencer

    // Address match used by the control, result and status decodes
    function automatic logic adcsq_hit(input logic [2:0] a, input logic [2:0] ofs);
        return a == ofs;
    endfunction

    assign wr_ctl = wr_i && (adcsq_hit(addr_i, `ADCSQ_OFS_MODE) ||
                             adcsq_hit(addr_i, `ADCSQ_OFS_CHAN));
    assign rd_res = rd_i && (adcsq_hit(addr_i, `ADCSQ_OFS_WIDE) ||
                             adcsq_hit(addr_i, `ADCSQ_OFS_NARROW));

    // ****************************************************************
    // Comparator synchroniser
    // ****************************************************************
    // Two flops before the sequencer sees the pin
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end else begin
            cmp_s1_q <= cmp_hi_i;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    adcsq_sar u_sar (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .run_i     (mode_q[`ADCSQ_RUN_BIT]),
        .abort_i   (wr_ctl),
        .fr_i      (mode_q[`ADCSQ_FR_MSB:`ADCSQ_FR_LSB]),
        .cmp_hi_i  (cmp_s2_q),
        .busy_o    (busy_o),
        .sample_o  (sample_o),
        .trial_o   (trial_o),
        .done_o    (done),
        .result_o  (res)
    );

    // ****************************************************************
    // Registers and conflict handling
    // ****************************************************************
    // Next values of software-visible state
    always_comb begin
        mode_d  = mode_q;
        chan_d  = chan_q;
        wide_d  = wide_q;
        pend_d  = pend_q;
        pval_d  = pval_q;
        flag_d  = flag_q;
        stat_d  = stat_q;
        mask_d  = mask_q;
        rdata_d = 16'h0000;
        ev      = 1'b0;
        // Held-back result lands once reads stop
        if (pend_q && !rd_res) begin // R01
            wide_d = pval_q;
            pend_d = 1'b0;
        end
        // Completion is dropped under a control write
        if (done && !wr_ctl) begin // R02
            ev = 1'b1; // R14
            if (rd_res) begin // R01
                pend_d = 1'b1;
                pval_d = res;
            end else begin
                wide_d = res;
                pend_d = 1'b0;
            end
        end
        // Register writes
        if (wr_i) begin
            case (addr_i)
                `ADCSQ_OFS_MODE: mode_d = wdata_i[7:0] & `ADCSQ_MODE_WMASK;
                `ADCSQ_OFS_CHAN: chan_d = wdata_i[1:0]; // R03
                `ADCSQ_OFS_MASK: mask_d = wdata_i[0];
                `ADCSQ_OFS_FLAG: flag_d = wdata_i[0]; // R17
                default:         mask_d = mask_q;
            endcase
        end
        // Status clears on read
        if (rd_i && adcsq_hit(addr_i, `ADCSQ_OFS_STAT)) begin
            stat_d = 1'b0;
        end
        // A completion wins over a clear
        if (ev) begin // R17
            flag_d = 1'b1;
            stat_d = 1'b1;
        end
        // Read data for the next cycle; results show the old value
        if (rd_i) begin
            case (addr_i)
                `ADCSQ_OFS_MODE:   rdata_d = {8'h00, mode_q};
                `ADCSQ_OFS_CHAN:   rdata_d = {14'h0000, chan_q};
                `ADCSQ_OFS_WIDE:   rdata_d = {6'h00, wide_q}; // R14
                `ADCSQ_OFS_NARROW: rdata_d = {8'h00, wide_q[9:2]}; // R14
                `ADCSQ_OFS_STAT:   rdata_d = {15'h0000, stat_q};
                `ADCSQ_OFS_MASK:   rdata_d = {15'h0000, mask_q};
                `ADCSQ_OFS_FLAG:   rdata_d = {15'h0000, flag_q};
                default:           rdata_d = 16'h0000;
            endcase
        end
        irq_d = stat_d && !mask_d;
    end

    // Register the software-visible state
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_q  <= `ADCSQ_RST_MODE;
            chan_q  <= `ADCSQ_RST_CHAN;
            wide_q  <= `ADCSQ_RST_RES;
            pend_q  <= 1'b0;
            pval_q  <= `ADCSQ_RST_RES;
            flag_q  <= 1'b0;
            stat_q  <= 1'b0;
            mask_q  <= `ADCSQ_RST_MASK;
            rdata_q <= 16'h0000;
            irq_q   <= 1'b0;
        end else begin
            mode_q  <= mode_d;
            chan_q  <= chan_d;
            wide_q  <= wide_d; // R06
            pend_q  <= pend_d;
            pval_q  <= pval_d;
            flag_q  <= flag_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end

    // Comparator powered by its enable even while idle
    assign comp_pwr_o = mode_q[`ADCSQ_CMPEN_BIT]; // R09
    assign chan_o     = chan_q;
    assign rdata_o    = rdata_q;
    assign irq_o      = irq_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_read_clash;
        done && rd_res && !wr_ctl;
    endsequence
    sequence s_stop_write;
        wr_i && adcsq_hit(addr_i, `ADCSQ_OFS_MODE) && !wdata_i[`ADCSQ_RUN_BIT];
    endsequence
    sequence s_stopped;
        !done ##1 (!done && !busy_o);
    endsequence

    a_read_wins: assert property (s_read_clash |=> pend_q && $stable(wide_q)) // R01
        else $error("result changed under a clashing read");
    a_read_then_store: assert property (s_read_clash ##1 !rd_res |=> wide_q == $past(res, 2)) // R01
        else $error("held result not stored after read");
    a_clash_keep: assert property (done && wr_ctl && !pend_q |=> $stable(wide_q)) // R02
        else $error("result stored despite control write");
    a_clash_noflag: assert property (done && wr_ctl && !flag_q && !stat_q // R02
                                     && !(wr_i && adcsq_hit(addr_i, `ADCSQ_OFS_FLAG))
                                     |=> !flag_q && !stat_q)
        else $error("done raised despite control write");
    a_chan_flag: assert property (wr_i && adcsq_hit(addr_i, `ADCSQ_OFS_CHAN) && flag_q // R03
                                  |=> flag_q)
        else $error("channel write cleared done flag");
    a_wait_state: assert property (!mode_q[`ADCSQ_RUN_BIT] |=> !busy_o && !sample_o) // R09
        else $error("sequencer active with run off");
    a_samp_first: assert property ($rose(busy_o) |-> sample_o) // R10
        else $error("conversion began without sampling");
    a_conv_span: assert property (done |-> !$past(sample_o, 1) && !$past(sample_o, 40)) // R10
        else $error("bit phase length wrong");
    a_repeat: assert property (done && mode_q[`ADCSQ_RUN_BIT] |-> sample_o) // R13
        else $error("no back-to-back restart");
    a_done_sets: assert property (done && !wr_ctl |=> flag_q && stat_q) // R17
        else $error("completion did not set flags");
    a_abort: assert property (wr_ctl && mode_q[`ADCSQ_RUN_BIT] |=> sample_o && !done) // R15
        else $error("control write did not restart");
    a_stop_now: assert property (s_stop_write |=> s_stopped) // R16
        else $error("run clear did not stop");
    a_irq_level: assert property (irq_o == (stat_q && !mask_q)) // R14
        else $error("interrupt line disagrees with status");
endmodule // adcsq_top

/* adcsq_params.svh */
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH
// ****************************************************************
// Register map offsets
// ****************************************************************
`define ADCSQ_OFS_MODE    3'h0
`define ADCSQ_OFS_CHAN    3'h1
`define ADCSQ_OFS_WIDE    3'h2
`define ADCSQ_OFS_NARROW  3'h3
`define ADCSQ_OFS_STAT    3'h4
`define ADCSQ_OFS_MASK    3'h5
`define ADCSQ_OFS_FLAG    3'h6
// ****************************************************************
// Field positions and writable bits
// ****************************************************************
`define ADCSQ_RUN_BIT     7
`define ADCSQ_CMPEN_BIT   0
`define ADCSQ_FR_LSB      3
`define ADCSQ_FR_MSB      5
`define ADCSQ_MODE_WMASK  8'hb9
// ****************************************************************
// Reset values
// ****************************************************************
`define ADCSQ_RST_MODE    8'h00
`define ADCSQ_RST_CHAN    2'h0
`define ADCSQ_RST_MASK    1'h1
`define ADCSQ_RST_RES     10'h000
// ****************************************************************
// Timing counts in ref_clk_i cycles, and the result MSB index
// ****************************************************************
`define ADCSQ_SAMP_BASE   8'h08
`define ADCSQ_BIT_CYC     8'h04
`define ADCSQ_RES_MSB     4'h9
`endif

/* adcsq_pkg.sv */
// ****************************************************************
// Shared types
// ****************************************************************
package adcsq_pkg;
    // Sequencer states
    typedef enum logic [1:0] {
        ADCSQ_IDLE   = 2'b00,
        ADCSQ_SAMPLE = 2'b01,
        ADCSQ_CONV   = 2'b10
    } adcsq_state_t;
endpackage

/* adcsq_sar.sv */
`include "adcsq_params.svh"
// ****************************************************************
// Successive-approximation sequencer
// ****************************************************************
module adcsq_sar import adcsq_pkg::*; (
    input  wire logic       ref_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       run_i,
    input  wire logic       abort_i,
    input  wire logic [2:0] fr_i,
    input  wire logic       cmp_hi_i,
    output logic            busy_o,
    output logic            sample_o,
    output logic [9:0]      trial_o,
    output logic            done_o,
    output logic [9:0]      result_o
);
    adcsq_state_t state_q, state_d;  // Sequencer state
    logic [7:0]   cnt_q,   cnt_d;    // Cycle counter within a phase
    logic [3:0]   bit_q,   bit_d;    // Bit under trial
    logic [9:0]   sar_q,   sar_d;    // Approximation register
    logic [9:0]   res_q,   res_d;    // Finished result
    logic         done_q,  done_d;   // Completion pulse
    logic         busy_q,  busy_d;   // Conversion in progress
    logic         smp_q,   smp_d;    // Sample switch on
    logic [7:0]   samp_cyc;          // Sampling length for this speed

    // Sampling length grows with the speed select
    assign samp_cyc = 8'(({5'h00, fr_i} + 8'h01) * `ADCSQ_SAMP_BASE);

    // Next-state logic
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        bit_d   = bit_q;
        sar_d   = sar_q;
        res_d   = res_q;
        done_d  = 1'b0;
        case (state_q)
            ADCSQ_IDLE: begin
                // Start sampling as soon as run is set
                if (run_i) begin // R13
                    state_d = ADCSQ_SAMPLE;
                    cnt_d   = samp_cyc - 8'h01;
                end
            end
            ADCSQ_SAMPLE: begin
                // Sampling time is part of the conversion
                if (cnt_q == 8'h00) begin // R10
                    state_d = ADCSQ_CONV;
                    bit_d   = `ADCSQ_RES_MSB;
                    sar_d   = 10'h200;
                    cnt_d   = `ADCSQ_BIT_CYC - 8'h01;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            ADCSQ_CONV: begin
                // Settle, then keep or drop the trial bit
                if (cnt_q == 8'h00) begin
                    sar_d[bit_q] = cmp_hi_i;
                    cnt_d        = `ADCSQ_BIT_CYC - 8'h01;
                    if (bit_q == 4'h0) begin
                        // Deliver and go straight on to the next one
                        res_d   = sar_d;
                        done_d  = 1'b1;
                        state_d = ADCSQ_SAMPLE; // R13
                        cnt_d   = samp_cyc - 8'h01;
                    end else begin
                        bit_d        = bit_q - 4'h1;
                        sar_d[bit_d] = 1'b1;
                    end
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            default: begin
                state_d = ADCSQ_IDLE;
            end
        endcase
        // Run cleared stops at once, result dropped
        if (!run_i) begin // R16
            state_d = ADCSQ_IDLE;
            done_d  = 1'b0;
        end else if (abort_i) begin // R15
            // Control write restarts from sampling
            state_d = ADCSQ_SAMPLE;
            cnt_d   = samp_cyc - 8'h01;
            sar_d   = 10'h000;
            done_d  = 1'b0;
        end
        busy_d = (state_d != ADCSQ_IDLE);
        smp_d  = (state_d == ADCSQ_SAMPLE);
    end

    // State registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ADCSQ_IDLE;
            cnt_q   <= 8'h00;
            bit_q   <= 4'h0;
            sar_q   <= 10'h000;
            res_q   <= `ADCSQ_RST_RES;
            done_q  <= 1'b0;
            busy_q  <= 1'b0;
            smp_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            bit_q   <= bit_d;
            sar_q   <= sar_d;
            res_q   <= res_d;
            done_q  <= done_d;
            busy_q  <= busy_d;
            smp_q   <= smp_d;
        end
    end

    assign busy_o   = busy_q;
    assign sample_o = smp_q;
    assign trial_o  = sar_q;
    assign done_o   = done_q;
    assign result_o = res_q;
endmodule // adcsq_sar

/* adcsq_ain_model.sv */
// ****************************************************************
// Analog sources on the four inputs, seen through the comparator
// ****************************************************************
module adcsq_ain_model (
    input  wire logic        ref_clk_i,
    input  wire logic        comp_pwr_i,
    input  wire logic [1:0]  chan_i,
    input  wire logic [9:0]  trial_i,
    input  wire logic [39:0] levels_i,
    output logic             cmp_hi_o
);
    logic       cmp_q = 1'b0;  // Last comparator decision
    logic       cmp_d;         // Next comparator decision
    logic [9:0] level;         // Level of the selected input

    // Compare the selected level with the trial tap
    always_comb begin
        level = levels_i[10*chan_i +: 10];
        if (comp_pwr_i) begin
            cmp_d = (level >= trial_i);
        end else begin
            // Unpowered comparator gives no steady answer
            cmp_d = ~cmp_q;
        end
    end

    // Register the decision, as a slow comparator would
    always_ff @(posedge ref_clk_i) begin
        cmp_q <= cmp_d;
    end

    assign cmp_hi_o = cmp_q;
endmodule  // adcsq_ain_model

/* adcsq_top_tb.sv */
`include "adcsq_params.svh"
// One counted comparison
`define ADCSQ_CHECK(got, exp, msg) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("wrong value at %0t ns: %s", $time, msg); \
        end \
    end
// ****************************************************************
// Testbench top
// ****************************************************************
module adcsq_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PER = 50;     // 20 MHz clock period
    logic        ref_clk = 1'b0; // System clock
    logic        resetn = 1'b0;  // Active low reset
    logic [2:0]  addr = 3'h0;    // Register index
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        cmp_hi;
    logic        comp_pwr;
    logic [1:0]  chan;
    logic        sample;
    logic [9:0]  trial;
    logic        busy;
    logic        irq;
    logic [39:0] levels = 40'h0; // Input levels, channel 0 lowest
    int          num_errors = 0;
    int          samples_checked = 0;

    always #(PER/2) ref_clk = ~ref_clk;

    adcsq_top DUT (.ref_clk_i(ref_clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cmp_hi_i(cmp_hi), .comp_pwr_o(comp_pwr),
        .chan_o(chan), .sample_o(sample), .trial_o(trial), .busy_o(busy), .irq_o(irq));
    adcsq_ain_model src (.ref_clk_i(ref_clk), .comp_pwr_i(comp_pwr), .chan_i(chan),
        .trial_i(trial), .levels_i(levels), .cmp_hi_o(cmp_hi));

    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task automatic bus_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    // Read, data taken in the cycle after the strobe
    task automatic expect_rd(input logic [2:0] a, input logic [15:0] e, input string m);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        `ADCSQ_CHECK(rdata, e, m)
    endtask

    // Count cycles until the interrupt line rises, bounded
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (irq !== 1'b1 && n < 400);
        // A line that never rises counts as a mismatch
        if (irq !== 1'b1) begin
            num_errors++;
            $display("wrong value at %0t ns: interrupt never came", $time);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        bus_wr(3'h7, 16'hffff);
        bus_wr(`ADCSQ_OFS_MODE, 16'h0046);
        for (int a = 0; a < 8; a++) begin
            expect_rd(3'(a), (a == 5) ? 16'h0001 : 16'h0000, "reset value");
        end
        `ADCSQ_CHECK({busy, irq, comp_pwr}, 3'b000, "idle outputs")
    endtask

    task automatic t_convert();
        int  n;
        time t0;
        levels[19:10] = 10'h2a5;
        bus_wr(`ADCSQ_OFS_CHAN, 16'h0001);
        bus_wr(`ADCSQ_OFS_MASK, 16'h0000);
        bus_wr(`ADCSQ_OFS_MODE, 16'h0009);
        tick(20);
        `ADCSQ_CHECK({comp_pwr, busy}, 2'b10, "waiting state")
        bus_wr(`ADCSQ_OFS_MODE, 16'h0089);
        wait_irq(n);
        // One cycle to start, sampling, bits, one cycle to raise the line
        `ADCSQ_CHECK(n, 2*`ADCSQ_SAMP_BASE + 10*`ADCSQ_BIT_CYC + 2, "first done")
        `ADCSQ_CHECK(trial, 10'h2a5, "approximation holds result")
        t0 = $time;
        levels[19:10] = 10'h15b;
        expect_rd(`ADCSQ_OFS_WIDE, 16'h02a5, "wide result");
        expect_rd(`ADCSQ_OFS_NARROW, 16'h00a9, "narrow result");
        expect_rd(`ADCSQ_OFS_FLAG, 16'h0001, "done flag");
        bus_wr(`ADCSQ_OFS_MASK, 16'h0001);
        tick(1);
        `ADCSQ_CHECK(irq, 1'b0, "masked irq")
        bus_wr(`ADCSQ_OFS_MASK, 16'h0000);
        tick(1);
        `ADCSQ_CHECK(irq, 1'b1, "unmasked irq")
        expect_rd(`ADCSQ_OFS_STAT, 16'h0001, "status");
        tick(1);
        `ADCSQ_CHECK(irq, 1'b0, "irq after status read")
        wait_irq(n);
        `ADCSQ_CHECK(int'(($time - t0) / PER), 56, "repeat period")
        expect_rd(`ADCSQ_OFS_WIDE, 16'h015b, "second result");
        expect_rd(`ADCSQ_OFS_STAT, 16'h0001, "status");
    endtask

    task automatic t_stop();
        bus_wr(`ADCSQ_OFS_FLAG, 16'h0000);
        #1;
        `ADCSQ_CHECK(busy, 1'b1, "running")
        bus_wr(`ADCSQ_OFS_MODE, 16'h0001);
        tick(2);
        `ADCSQ_CHECK({busy, comp_pwr}, 2'b01, "stopped")
        tick(120);
        `ADCSQ_CHECK({irq, sample}, 2'b00, "no result after stop")
        expect_rd(`ADCSQ_OFS_FLAG, 16'h0000, "flag after stop");
    endtask

    task automatic t_abort();
        int n;
        levels[29:20] = 10'h3c1;
        levels[39:30] = 10'h0c7;
        bus_wr(`ADCSQ_OFS_CHAN, 16'h0002);
        bus_wr(`ADCSQ_OFS_MODE, 16'h0081);
        wait_irq(n);
        expect_rd(`ADCSQ_OFS_WIDE, 16'h03c1, "channel 2 result");
        expect_rd(`ADCSQ_OFS_STAT, 16'h0001, "status");
        tick(20);
        `ADCSQ_CHECK(sample, 1'b0, "in bit phase")
        bus_wr(`ADCSQ_OFS_CHAN, 16'h0003);
        #1;
        `ADCSQ_CHECK({busy, sample}, 2'b11, "restart sampling")
        `ADCSQ_CHECK(chan, 2'h3, "channel output")
        expect_rd(`ADCSQ_OFS_FLAG, 16'h0001, "flag kept");
        wait_irq(n);
        // Two cycles already spent on the flag read
        `ADCSQ_CHECK(n, `ADCSQ_SAMP_BASE + 10*`ADCSQ_BIT_CYC - 1, "restart time")
        expect_rd(`ADCSQ_OFS_WIDE, 16'h00c7, "channel 3 result");
    endtask

    task automatic t_rd_conflict();
        expect_rd(`ADCSQ_OFS_STAT, 16'h0001, "status");
        bus_wr(`ADCSQ_OFS_MODE, 16'h0001);
        bus_wr(`ADCSQ_OFS_FLAG, 16'h0000);
        levels[39:30] = 10'h21e;
        bus_wr(`ADCSQ_OFS_MODE, 16'h0081);
        repeat (42) @(posedge ref_clk);
        // Reads back to back at edges 44 to 50; done is taken at edge 50, the last read
        for (int i = 0; i <= 7; i++) begin
            @(posedge ref_clk);
            addr <= `ADCSQ_OFS_WIDE;
            rd <= (i < 7);
            #1;
            if (i > 0) `ADCSQ_CHECK(rdata, 16'h00c7, "read during done")
        end
        expect_rd(`ADCSQ_OFS_WIDE, 16'h021e, "stored after reads");
        expect_rd(`ADCSQ_OFS_FLAG, 16'h0001, "flag set");
    endtask

    task automatic t_wr_conflict();
        expect_rd(`ADCSQ_OFS_STAT, 16'h0001, "status");
        bus_wr(`ADCSQ_OFS_MODE, 16'h0001);
        bus_wr(`ADCSQ_OFS_FLAG, 16'h0000);
        levels[39:30] = 10'h333;
        bus_wr(`ADCSQ_OFS_MODE, 16'h0081);
        // Channel write taken at edge 50, together with done
        repeat (48) @(posedge ref_clk);
        bus_wr(`ADCSQ_OFS_CHAN, 16'h0003);
        tick(4);
        `ADCSQ_CHECK(irq, 1'b0, "no irq on conflict")
        expect_rd(`ADCSQ_OFS_FLAG, 16'h0000, "no flag on conflict");
        expect_rd(`ADCSQ_OFS_WIDE, 16'h021e, "result not stored");
        bus_wr(`ADCSQ_OFS_MODE, 16'h0000);
    endtask

    // ****************************************************************
    // Verdict, sequence and watchdog
    // ****************************************************************
    task automatic print_verdict();
        $display("errors %0d, comparisons %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset();
        t_convert();
        t_stop();
        t_abort();
        t_rd_conflict();
        t_wr_conflict();
        print_verdict();
    end

    // Cut a hang short, far beyond the expected run
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        $display("wrong value at %0t ns: watchdog expired", $time);
        print_verdict();
    end
endmodule  // adcsq_top_tb
